// File: cas_pkg.sv
// shared constants and types for the bit-rate finder and identifier scanner
package cas_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned NUM_RATES   = 5;
  localparam int unsigned RATE_W      = 3;
  localparam logic [15:0] RATE_KBPS [NUM_RATES] =
    '{16'h03E8, 16'h01F4, 16'h00FA, 16'h007D, 16'h0032};
  localparam logic [7:0]  SCAN_DEF_S  = 8'h0A;
  localparam int unsigned TRIAL_MS    = 50;
  localparam int unsigned STD_ID_W    = 11;
  localparam int unsigned EXT_ID_W    = 29;
  localparam logic [2:0]  STUFF_RUN   = 3'h5;
  localparam logic [3:0]  IDLE_BITS   = 4'hB;
  localparam logic [3:0]  EOF_BITS    = 4'h7;
  localparam logic [5:0]  IDX_SOF     = 6'h00;
  localparam logic [5:0]  IDX_ID_LAST = 6'h0B;
  localparam logic [5:0]  IDX_IDE     = 6'h0D;
  localparam logic [5:0]  IDX_EXT_1ST = 6'h0E;
  localparam logic [5:0]  IDX_EXT_RTR = 6'h20;
  localparam int unsigned DIGITS_W    = 40;

  typedef enum logic [1:0] {ST_IDLE, ST_BAUD, ST_SCAN} cas_state_t;
  typedef enum logic [1:0] {RX_HUNT, RX_WAIT_SOF, RX_HDR, RX_TAIL}
    cas_rx_state_t;

  function automatic logic [15:0] cas_bit_cyc(input logic [RATE_W-1:0] idx);
    return 16'(CLK_HZ / (32'(RATE_KBPS[idx]) * 32'h0000_03E8));
  endfunction : cas_bit_cyc
endpackage : cas_pkg

// File: cas_frame_rx.sv
// frame header receiver: idle sync, destuffing, identifier capture
`timescale 1ns/1ps
module cas_frame_rx
  import cas_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                enable,
  input  wire logic [15:0]         bit_cyc,
  input  wire logic                invert,
  input  wire logic                rx_level,
  output logic                     frame_ok,
  output logic [EXT_ID_W-1:0]      frame_id,
  output logic                     frame_ext
);
  cas_rx_state_t st_q;
  logic [15:0]   tmr_q;
  logic [3:0]    run_q;
  logic [5:0]    idx_q;
  logic          last_q;
  logic [2:0]    same_q;
  logic          rxb;
  logic          tick;

  assign rxb  = rx_level ^ invert;
  assign tick = (tmr_q == 16'h0000);

  always_ff @(posedge clk)
  begin
    if (!reset_n || !enable || st_q == RX_WAIT_SOF)
      tmr_q <= bit_cyc >> 1;
    else if (tick)
      tmr_q <= bit_cyc - 16'h0001;
    else
      tmr_q <= tmr_q - 16'h0001;
  end

  // a wrong rate shows up as stuff errors or a bad start bit
  always_ff @(posedge clk)
  begin
    frame_ok <= 1'b0;
    if (!reset_n || !enable)
    begin
      st_q      <= RX_HUNT;
      run_q     <= 4'h0;
      idx_q     <= 6'h00;
      last_q    <= 1'b1;
      same_q    <= 3'h0;
      frame_id  <= '0;
      frame_ext <= 1'b0;
    end
    else
    begin
      case (st_q)
        RX_HUNT:
          if (tick)
          begin
            run_q <= rxb ? run_q + 4'h1 : 4'h0;
            if (rxb && run_q == IDLE_BITS - 4'h1)
              st_q <= RX_WAIT_SOF;
          end
        RX_WAIT_SOF:
          if (!rxb)
          begin
            st_q     <= RX_HDR;
            idx_q    <= IDX_SOF;
            last_q   <= 1'b1;
            same_q   <= 3'h0;
            frame_id <= '0;
          end
        RX_HDR:
          if (tick)
          begin
            if (same_q == STUFF_RUN)
            begin
              if (rxb == last_q)
                st_q <= RX_HUNT;
              last_q <= rxb;
              same_q <= 3'h1;
            end
            else
            begin
              same_q <= (rxb == last_q) ? same_q + 3'h1 : 3'h1;
              last_q <= rxb;
              idx_q  <= idx_q + 6'h01;
              run_q  <= 4'h0;
              if (idx_q == IDX_SOF && rxb)
                st_q <= RX_HUNT;
              else if ((idx_q > IDX_SOF && idx_q <= IDX_ID_LAST) ||
                       (idx_q >= IDX_EXT_1ST && idx_q < IDX_EXT_RTR))
                frame_id <= {frame_id[EXT_ID_W-2:0], rxb};
              else if (idx_q == IDX_IDE)
              begin
                frame_ext <= rxb;
                if (!rxb)
                  st_q <= RX_TAIL;
              end
              else if (idx_q == IDX_EXT_RTR)
                st_q <= RX_TAIL;
            end
          end
        RX_TAIL:
          if (tick)
          begin
            run_q <= rxb ? run_q + 4'h1 : 4'h0;
            if (rxb && run_q == EOF_BITS - 4'h1)
            begin
              frame_ok <= 1'b1;
              st_q     <= RX_WAIT_SOF;
            end
          end
        default:
          st_q <= RX_HUNT;
      endcase
    end
  end
endmodule : cas_frame_rx

// File: cas_scanner.sv
// passive bus monitor: automatic bit-rate search and identifier census
`timescale 1ns/1ps
module cas_scanner
  import cas_pkg::*;
#(
  parameter int unsigned MAX_IDS      = 16,
  parameter int unsigned CNT_W        = 16,
  parameter int unsigned SEC_CYCLES   = CLK_HZ,
  parameter int unsigned TRIAL_CYCLES = CLK_HZ / 1000 * TRIAL_MS,
  localparam int unsigned IDX_W       = $clog2(MAX_IDS),
  localparam int unsigned NUM_W       = $clog2(MAX_IDS + 1)
)
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 can_rx,
  input  wire logic                 start_baud,
  input  wire logic                 start_scan,
  input  wire logic                 abort_req,
  input  wire logic                 mode_higher_layer,
  input  wire logic [7:0]           scan_secs,
  input  wire logic                 fmt_hex,
  input  wire logic [IDX_W-1:0]     rd_idx,
  output logic                      baud_busy,
  output logic                      baud_ok,
  output logic [RATE_W-1:0]         baud_rate_idx,
  output logic [15:0]               baud_kbps,
  output logic                      hl_inverted,
  output logic                      scan_busy,
  output logic                      scan_done,
  output logic                      aborted,
  output logic [NUM_W-1:0]          id_count,
  output logic                      rd_valid,
  output logic                      rd_ext,
  output logic [EXT_ID_W-1:0]       rd_id,
  output logic [CNT_W-1:0]          rd_cnt,
  output logic [DIGITS_W-1:0]       rd_digits,
  output logic                      rd_hex_suffix
);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  cas_state_t          st_q;
  logic [2:0]          sync_q;
  logic                rx_lvl_q;
  logic [RATE_W-1:0]   rate_q;
  logic                inv_q;
  logic                restart_q;
  logic                scan_after_q;
  logic [31:0]         trial_q;
  logic [31:0]         sec_q;
  logic [7:0]          secs_left_q;
  logic                rx_en;
  logic                f_ok;
  logic [EXT_ID_W-1:0] f_id;
  logic                f_ext;
  logic                ent_v   [MAX_IDS];
  logic                ent_ext [MAX_IDS];
  logic [EXT_ID_W-1:0] ent_id  [MAX_IDS];
  logic [CNT_W-1:0]    ent_cnt [MAX_IDS];
  logic [MAX_IDS-1:0]  hit;

  function automatic logic [DIGITS_W-1:0] to_bcd(input logic [EXT_ID_W-1:0] v);
    logic [DIGITS_W-1:0] b;
    b = '0;
    for (int i = EXT_ID_W - 1; i >= 0; i--)
    begin
      for (int d = 0; d < DIGITS_W / 4; d++)
        if (b[d*4 +: 4] > 4'h4)
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
      b = {b[DIGITS_W-2:0], v[i]};
    end
    return b;
  endfunction : to_bcd

  // three stages; the level moves only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync_q   <= 3'h7;
      rx_lvl_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], can_rx};
      if (sync_q[1] == sync_q[2])
        rx_lvl_q <= sync_q[2];
    end
  end

  // one idle cycle between trials resynchronises the receiver
  assign rx_en = (st_q != ST_IDLE) && !restart_q;

  cas_frame_rx u_rx (
    .clk       (clk),
    .reset_n   (reset_n),
    .enable    (rx_en),
    .bit_cyc   (cas_bit_cyc(rate_q)),
    .invert    (inv_q),
    .rx_level  (rx_lvl_q),
    .frame_ok  (f_ok),
    .frame_id  (f_id),
    .frame_ext (f_ext)
  );

  // search and scan sequencing
  always_ff @(posedge clk)
  begin
    restart_q <= 1'b0;
    if (!reset_n)
    begin
      st_q          <= ST_IDLE;
      rate_q        <= '0;
      inv_q         <= 1'b0;
      scan_after_q  <= 1'b0;
      trial_q       <= '0;
      sec_q         <= '0;
      secs_left_q   <= '0;
      baud_busy     <= 1'b0;
      baud_ok       <= 1'b0;
      baud_rate_idx <= '0;
      baud_kbps     <= '0;
      hl_inverted   <= 1'b0;
      scan_busy     <= 1'b0;
      scan_done     <= 1'b0;
      aborted       <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (start_baud || (start_scan && !mode_higher_layer))
          begin
            st_q         <= ST_BAUD;
            scan_after_q <= start_scan && !mode_higher_layer;
            rate_q       <= '0;
            inv_q        <= 1'b0;
            trial_q      <= '0;
            restart_q    <= 1'b1;
            baud_busy    <= 1'b1;
            baud_ok      <= 1'b0;
            hl_inverted  <= 1'b0;
            scan_done    <= 1'b0;
            aborted      <= 1'b0;
          end
        ST_BAUD:
          if (abort_req)
          begin
            st_q      <= ST_IDLE;
            baud_busy <= 1'b0;
            aborted   <= 1'b1;
          end
          else if (f_ok)
          begin
            baud_busy     <= 1'b0;
            baud_ok       <= 1'b1;
            baud_rate_idx <= rate_q;
            baud_kbps     <= RATE_KBPS[rate_q];
            hl_inverted   <= inv_q;
            st_q          <= scan_after_q ? ST_SCAN : ST_IDLE;
            scan_busy     <= scan_after_q;
            sec_q         <= '0;
            secs_left_q   <= (scan_secs == 8'h00) ? SCAN_DEF_S : scan_secs;
          end
          else if (trial_q == TRIAL_CYCLES - 1)
          begin
            // each rate is tried straight, then with the pair swapped
            trial_q   <= '0;
            restart_q <= 1'b1;
            inv_q     <= !inv_q;
            if (inv_q)
              rate_q <= (rate_q == RATE_W'(NUM_RATES - 1)) ?
                        '0 : rate_q + 1'b1;
          end
          else
            trial_q <= trial_q + 32'h0000_0001;
        ST_SCAN:
          // abort is ignored here: the window always runs out in full
          if (sec_q == SEC_CYCLES - 1)
          begin
            sec_q       <= '0;
            secs_left_q <= secs_left_q - 8'h01;
            if (secs_left_q == 8'h01)
            begin
              st_q      <= ST_IDLE;
              scan_busy <= 1'b0;
              scan_done <= 1'b1;
            end
          end
          else
            sec_q <= sec_q + 32'h0000_0001;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // format and id both have to match, so 11- and 29-bit ids never merge
  for (genvar g = 0; g < MAX_IDS; g++)
  begin : g_hit
    assign hit[g] = ent_v[g] && ent_ext[g] == f_ext && ent_id[g] == f_id;
  end

  // identifier table
  always_ff @(posedge clk)
  begin
    if (!reset_n || (st_q == ST_BAUD && f_ok))
    begin
      id_count <= '0;
      for (int i = 0; i < MAX_IDS; i++)
      begin
        ent_v[i]   <= 1'b0;
        ent_ext[i] <= 1'b0;
        ent_id[i]  <= '0;
        ent_cnt[i] <= '0;
      end
    end
    else if (st_q == ST_SCAN && f_ok)
    begin
      if (|hit)
      begin
        for (int i = 0; i < MAX_IDS; i++)
          if (hit[i] && ent_cnt[i] != CNT_MAX)
            ent_cnt[i] <= ent_cnt[i] + 1'b1;
      end
      else if (id_count < NUM_W'(MAX_IDS))
      begin
        ent_v[IDX_W'(id_count)]   <= 1'b1;
        ent_ext[IDX_W'(id_count)] <= f_ext;
        ent_id[IDX_W'(id_count)]  <= f_id;
        ent_cnt[IDX_W'(id_count)] <= CNT_W'(1);
        id_count                  <= id_count + 1'b1;
      end
    end
  end

  // read port, one cycle behind rd_idx and fmt_hex
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_valid      <= 1'b0;
      rd_ext        <= 1'b0;
      rd_id         <= '0;
      rd_cnt        <= '0;
      rd_digits     <= '0;
      rd_hex_suffix <= 1'b0;
    end
    else
    begin
      rd_valid      <= ent_v[rd_idx];
      rd_ext        <= ent_ext[rd_idx];
      rd_id         <= ent_id[rd_idx];
      rd_cnt        <= ent_cnt[rd_idx];
      rd_hex_suffix <= fmt_hex;
      rd_digits     <= fmt_hex ? DIGITS_W'(ent_id[rd_idx]) :
                                 to_bcd(ent_id[rd_idx]);
    end
  end

  // helper: scan length in cycles and the window it was given
  logic [39:0] scan_len_q;
  logic [7:0]  win_q;
  always_ff @(posedge clk)
  begin
    if (!reset_n || st_q != ST_SCAN)
      scan_len_q <= '0;
    else
      scan_len_q <= scan_len_q + 40'h01;
    if (!reset_n)
      win_q <= '0;
    else if (st_q == ST_BAUD && f_ok)
      win_q <= (scan_secs == 8'h00) ? SCAN_DEF_S : scan_secs;
  end

  property p_abort;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_BAUD && abort_req) |=> (!baud_busy && aborted && !baud_ok);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not cancel rate search");

  property p_found;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_BAUD && f_ok && !abort_req) |=>
      (baud_ok && !baud_busy && baud_rate_idx == $past(rate_q));
  endproperty
  a_found: assert property (p_found)
    else $error("received frame did not end rate search");

  property p_polarity;
    @(posedge clk) disable iff (!reset_n)
    $rose(baud_ok) |-> hl_inverted == $past(inv_q);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("inversion flag does not match working polarity");

  property p_scan_order;
    @(posedge clk) disable iff (!reset_n)
    $rose(scan_busy) |-> (baud_ok && $past(st_q) == ST_BAUD);
  endproperty
  a_scan_order: assert property (p_scan_order)
    else $error("scan started without completed rate detection");

  property p_cap;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_SCAN && f_ok && hit == '0 &&
     id_count == NUM_W'(MAX_IDS)) |=> $stable(id_count);
  endproperty
  a_cap: assert property (p_cap)
    else $error("table grew beyond its limit");

  property p_new_entry;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_SCAN && f_ok && hit == '0 && id_count < NUM_W'(MAX_IDS))
      |=> (id_count == $past(id_count) + 1'b1);
  endproperty
  a_new_entry: assert property (p_new_entry)
    else $error("new identifier not entered");

  property p_saturate;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_SCAN && ent_cnt[0] == CNT_MAX) |=> ent_cnt[0] == CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("occurrence counter wrapped");

  property p_full_window;
    @(posedge clk) disable iff (!reset_n)
    $rose(scan_done) |->
      scan_len_q == 40'(win_q) * 40'(SEC_CYCLES);
  endproperty
  a_full_window: assert property (p_full_window)
    else $error("scan window length wrong");
endmodule : cas_scanner

// File: cas_node_model.sv
// behavioural bus node sending minimal data frames at the fastest rate
`timescale 1ns/1ps
module cas_node_model
  import cas_pkg::*;
(
  input  wire logic clk,
  input  wire logic swap,
  output logic      can_rx
);
  localparam int BIT_CYC = CLK_HZ / (int'(RATE_KBPS[0]) * 1000);

  logic busy;

  initial
  begin
    busy   = 1'b0;
    can_rx = 1'b1;
  end

  // swapped wires turn the recessive idle level into a low line
  always @(swap)
  begin
    if (!busy)
      can_rx = ~swap;
  end

  task automatic send_bit(input logic b);
    @(posedge clk);
    #1;
    can_rx = b ^ swap;
    repeat (BIT_CYC - 1) @(posedge clk);
  endtask : send_bit

  // tail is ack, delimiters and end of frame, all left recessive
  task automatic send_frame(input logic ext, input logic [28:0] id);
    logic hdr[$];
    logic last;
    int   run;
    busy = 1'b1;
    hdr.push_back(1'b0);
    for (int i = 28; i >= 18; i--)
      hdr.push_back(ext ? id[i] : id[i-18]);
    if (ext)
    begin
      hdr.push_back(1'b1);
      hdr.push_back(1'b1);
      for (int i = 17; i >= 0; i--)
        hdr.push_back(id[i]);
    end
    // remote flag, reserved bits, zero length code
    repeat (7) hdr.push_back(1'b0);
    repeat (12) send_bit(1'b1);
    run  = 0;
    last = 1'b1;
    foreach (hdr[k])
    begin
      send_bit(hdr[k]);
      run  = (hdr[k] == last) ? run + 1 : 1;
      last = hdr[k];
      if (run == 5)
      begin
        send_bit(~last);
        last = ~last;
        run  = 1;
      end
    end
    repeat (10) send_bit(1'b1);
    busy = 1'b0;
  endtask : send_frame
endmodule : cas_node_model

// File: cas_scanner_tb.sv
// self-checking bench for the bit-rate finder and identifier scanner
`timescale 1ns/1ps
module cas_scanner_tb
  import cas_pkg::*;
;
  // short second and trial keep the run small; table of two, 2-bit counts
  localparam int SEC   = 4500;
  localparam int TRIAL = 10000;

  logic        clk, reset_n, can_rx, swap, fmt_hex;
  logic        start_baud, start_scan, abort_req, mode_higher_layer;
  logic [7:0]  scan_secs;
  logic [0:0]  rd_idx;
  logic        baud_busy, baud_ok, hl_inverted, scan_busy, scan_done;
  logic        aborted, rd_valid, rd_ext, rd_hex_suffix;
  logic [2:0]  baud_rate_idx;
  logic [15:0] baud_kbps;
  logic [1:0]  id_count, rd_cnt;
  logic [28:0] rd_id;
  logic [39:0] rd_digits;
  int          error_cnt = 0;
  int          checked = 0;

  cas_scanner #(
    .MAX_IDS      (2),
    .CNT_W        (2),
    .SEC_CYCLES   (SEC),
    .TRIAL_CYCLES (TRIAL)
  ) dut_u (
    .clk               (clk),
    .reset_n           (reset_n),
    .can_rx            (can_rx),
    .start_baud        (start_baud),
    .start_scan        (start_scan),
    .abort_req         (abort_req),
    .mode_higher_layer (mode_higher_layer),
    .scan_secs         (scan_secs),
    .fmt_hex           (fmt_hex),
    .rd_idx            (rd_idx),
    .baud_busy         (baud_busy),
    .baud_ok           (baud_ok),
    .baud_rate_idx     (baud_rate_idx),
    .baud_kbps         (baud_kbps),
    .hl_inverted       (hl_inverted),
    .scan_busy         (scan_busy),
    .scan_done         (scan_done),
    .aborted           (aborted),
    .id_count          (id_count),
    .rd_valid          (rd_valid),
    .rd_ext            (rd_ext),
    .rd_id             (rd_id),
    .rd_cnt            (rd_cnt),
    .rd_digits         (rd_digits),
    .rd_hex_suffix     (rd_hex_suffix)
  );

  cas_node_model u_node (
    .clk    (clk),
    .swap   (swap),
    .can_rx (can_rx)
  );

  always #4 clk = ~clk;

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse

  task automatic check(input string name, input logic [47:0] seen,
                       input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic t_reset();
    check("reset", {baud_busy, baud_ok, scan_busy, scan_done, aborted,
                    hl_inverted, id_count}, 48'h0);
  endtask : t_reset

  task automatic t_higher_layer();
    mode_higher_layer = 1'b1;
    pulse(start_scan);
    repeat (3) step();
    check("hl_refused", {baud_busy, scan_busy}, 2'b00);
    mode_higher_layer = 1'b0;
  endtask : t_higher_layer

  // silent bus: search must go on past a trial until cancelled
  task automatic t_abort();
    pulse(start_baud);
    repeat (TRIAL + 1000) step();
    check("searching", {baud_busy, baud_ok}, 2'b10);
    pulse(abort_req);
    step();
    step();
    check("aborted", {baud_busy, baud_ok, aborted}, 3'b001);
  endtask : t_abort

  task automatic t_swapped();
    int n;
    n = 0;
    swap = 1'b1;
    step();
    pulse(start_baud);
    fork
      repeat (4) u_node.send_frame(1'b0, 29'h3A5);
      while (baud_ok !== 1'b1 && n < 30000)
      begin
        step();
        n++;
      end
    join
    check("swapped", {baud_ok, hl_inverted, baud_busy, scan_busy},
          4'b1100);
    check("rate", {baud_rate_idx, baud_kbps}, {3'h0, RATE_KBPS[0]});
    swap = 1'b0;
  endtask : t_swapped

  // a set window of one second replaces the default length
  task automatic t_short_scan();
    int n;
    n = 0;
    scan_secs = 8'h01;
    pulse(start_scan);
    fork
      u_node.send_frame(1'b0, 29'h055);
      begin
        while (scan_busy !== 1'b1 && n < 20000)
        begin
          step();
          n++;
        end
        n = 0;
        while (scan_busy === 1'b1 && n < 20000)
        begin
          step();
          n++;
        end
        check("short_window", 48'(n), 48'(SEC));
      end
    join
    // the frame that ended the search is not a table entry
    check("search_frame", id_count, 2'h0);
  endtask : t_short_scan

  task automatic t_scan();
    int n;
    n = 0;
    scan_secs = 8'h00;
    pulse(start_scan);
    step();
    check("search_first", {scan_busy, baud_busy}, 2'b01);
    fork
      begin
        u_node.send_frame(1'b0, 29'h055);
        u_node.send_frame(1'b0, 29'h123);
        u_node.send_frame(1'b1, 29'h123);
        u_node.send_frame(1'b0, 29'h7FF);
        repeat (3) u_node.send_frame(1'b0, 29'h123);
      end
      begin
        while (scan_busy !== 1'b1 && n < 20000)
        begin
          step();
          n++;
        end
        check("found", {baud_ok, baud_rate_idx, hl_inverted, baud_kbps},
              {1'b1, 3'h0, 1'b0, RATE_KBPS[0]});
        n = 0;
        // an abort in mid-window must not shorten the scan
        while (scan_busy === 1'b1 && n < 60000)
        begin
          abort_req = (n == 100);
          step();
          n++;
        end
        check("window", 48'(n), 48'(int'(SCAN_DEF_S) * SEC));
        check("done", {scan_done, aborted}, 2'b10);
      end
    join
    rd_idx  = 1'b0;
    fmt_hex = 1'b1;
    step();
    step();
    check("entry0", {rd_valid, rd_ext, rd_id, rd_cnt},
          {1'b1, 1'b0, 29'h123, 2'h3});
    check("hex", {rd_hex_suffix, rd_digits}, {1'b1, 40'h123});
    fmt_hex = 1'b0;
    step();
    step();
    check("dec", {rd_hex_suffix, rd_digits}, {1'b0, 40'h291});
    rd_idx = 1'b1;
    step();
    step();
    check("entry1", {rd_valid, rd_ext, rd_id, rd_cnt},
          {1'b1, 1'b1, 29'h123, 2'h1});
    check("count", id_count, 2'h2);
  endtask : t_scan

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    swap = 1'b0;
    start_baud = 1'b0;
    start_scan = 1'b0;
    abort_req = 1'b0;
    mode_higher_layer = 1'b0;
    scan_secs = 8'h00;
    fmt_hex = 1'b0;
    rd_idx = 1'b0;
    repeat (6) step();
    reset_n = 1'b1;
    step();
    t_reset();
    t_higher_layer();
    t_abort();
    t_swapped();
    t_short_scan();
    t_scan();
    test_done();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : cas_scanner_tb
